// ---- verilog/mrc_pkg.sv ----
// Package: constants for the mode register and calibration command block
package mrc_pkg;

  // ----------------------------------------------------------------------
  // Command decode and addresses
  // ----------------------------------------------------------------------
  localparam logic [7:0] MR_ADDR_TEMP   = 8'h04;
  localparam logic [7:0] MR_ADDR_PATA   = 8'h20;
  localparam logic [7:0] MR_ADDR_PATB   = 8'h28;
  localparam logic [7:0] MR_ADDR_ZQ     = 8'h0a;
  localparam logic [7:0] MR_ADDR_RESET  = 8'h3f;
  localparam logic [7:0] MR_ADDR_CTRL   = 8'h01;
  localparam logic [7:0] ZQ_CODE_INIT   = 8'hff;
  localparam logic [7:0] ZQ_CODE_LONG   = 8'hab;
  localparam logic [7:0] ZQ_CODE_SHORT  = 8'h56;
  localparam logic [7:0] ZQ_CODE_RESET  = 8'hc3;
  localparam logic [7:0] CTRL_RESET_VAL = 8'h00;

  // ----------------------------------------------------------------------
  // Calibration patterns, beat 0 in bit 0
  // ----------------------------------------------------------------------
  localparam logic [3:0] PAT_A = 4'h5;
  localparam logic [3:0] PAT_B = 4'hc;
  localparam logic [2:0] TEMP_HOT_CODE = 3'h3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TSI_MS         = 32;
  localparam int TSI_CYC        = TSI_MS * 1000000 / CLK_PERIOD_NS;
  localparam int MRR_CYC        = 2;
  localparam int MRW_CYC        = 5;
  localparam int BURST_BEATS    = 4;
  localparam int ZQINIT_CYC     = 100000;
  localparam int ZQCL_CYC       = 36000;
  localparam int ZQCS_CYC       = 9000;
  localparam int ZQRESET_CYC    = 5;
  localparam int INIT_CYC       = 100;

  typedef enum logic [2:0] {
    MRC_IDLE, MRC_MRR, MRC_MRW, MRC_ZQ, MRC_RESET
  } mrc_state_type;

endpackage : mrc_pkg

// ---- verilog/mrc_core.sv ----
// Mode register write/read, DQ calibration, temp status and ZQ sequencing
`timescale 1ns/100ps
module mrc_core
  import mrc_pkg::*;
#(
  parameter int TSI_CYCLES    = TSI_CYC,
  parameter int ZQINIT_CYCLES = ZQINIT_CYC,
  parameter int ZQCL_CYCLES   = ZQCL_CYC,
  parameter int ZQCS_CYCLES   = ZQCS_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        cs_n,
  input  wire logic [9:0]  ca_rise,
  input  wire logic [9:0]  ca_fall,
  input  wire logic        zq_tied_high,
  input  wire logic [2:0]  temp_sense,
  output logic [15:0]      dq_out,
  output logic             dq_oe,
  output logic [7:0]       ctrl_reg_q,
  output logic [2:0]       temp_status,
  output logic             mrw_busy,
  output logic             reset_busy,
  output logic             zq_busy,
  output logic [1:0]       zq_kind,
  output logic             drv_default
);

  // ----------------------------------------------------------------------
  // Input synchronisers for off-domain pins
  // ----------------------------------------------------------------------
  logic       zq_meta_reg, zq_sync_reg;
  logic [2:0] ts_meta_reg, ts_sync_reg;
  always_ff @(posedge core_clk) begin
    zq_meta_reg <= zq_tied_high;
    zq_sync_reg <= zq_meta_reg;
    ts_meta_reg <= temp_sense;
    ts_sync_reg <= ts_meta_reg;
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic       is_mrw, is_mrr;
  logic [7:0] cmd_addr, cmd_data;
  assign is_mrw   = !cs_n && ca_rise[3:0] == 4'h0;
  assign is_mrr   = !cs_n && ca_rise[3:0] == 4'h8;
  assign cmd_addr = {ca_fall[1:0], ca_rise[9:4]};
  assign cmd_data = ca_fall[9:2];

  mrc_state_type state_reg;
  logic [16:0]   cnt_reg;
  logic [3:0]    pat_reg;
  logic [1:0]    beat_reg;
  logic          pat_sel_reg;
  logic          idle;
  assign idle = state_reg == MRC_IDLE;
  // Calibration or device reset starts on this edge
  logic zq_go, rst_go;
  assign zq_go  = idle && is_mrw && cmd_addr == MR_ADDR_ZQ && !zq_sync_reg &&
                  (cmd_data inside {ZQ_CODE_INIT, ZQ_CODE_LONG,
                                    ZQ_CODE_SHORT, ZQ_CODE_RESET});
  assign rst_go = idle && is_mrw && cmd_addr == MR_ADDR_RESET;

  // ----------------------------------------------------------------------
  // Sequencer: every command period ends on a count; NOPs are assumed
  // during it, so new commands are ignored until idle again
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= MRC_RESET;
      cnt_reg   <= 17'(INIT_CYC - 1);
      zq_kind   <= 2'h0;
    end else if (!idle) begin
      if (cnt_reg == 17'h0)
        state_reg <= MRC_IDLE;
      else
        cnt_reg <= cnt_reg - 17'h1;
    end else if (is_mrr) begin
      state_reg <= MRC_MRR;
      cnt_reg   <= 17'(MRR_CYC - 1);
    end else if (rst_go) begin
      state_reg <= MRC_RESET;
      cnt_reg   <= 17'(INIT_CYC - 1);
    end else if (zq_go) begin
      // With the pin strapped high or an unknown code it is a plain write
      state_reg <= MRC_ZQ;
      unique case (cmd_data)
        ZQ_CODE_INIT: begin
          zq_kind <= 2'h0;
          cnt_reg <= 17'(ZQINIT_CYCLES - 1);
        end
        ZQ_CODE_LONG: begin
          zq_kind <= 2'h1;
          cnt_reg <= 17'(ZQCL_CYCLES - 1);
        end
        ZQ_CODE_SHORT: begin
          zq_kind <= 2'h2;
          cnt_reg <= 17'(ZQCS_CYCLES - 1);
        end
        ZQ_CODE_RESET: begin
          zq_kind <= 2'h3;
          cnt_reg <= 17'(ZQRESET_CYC - 1);
        end
      endcase
    end else if (is_mrw) begin
      state_reg <= MRC_MRW;
      cnt_reg   <= 17'(MRW_CYC - 1);
    end
  end

  // ----------------------------------------------------------------------
  // Busy flags straight from flops
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mrw_busy   <= 1'b0;
      reset_busy <= 1'b1;
      zq_busy    <= 1'b0;
    end else begin
      mrw_busy   <= state_reg == MRC_MRW && cnt_reg != 17'h0
                    || idle && is_mrw && !zq_go && !rst_go;
      reset_busy <= state_reg == MRC_RESET && cnt_reg != 17'h0
                    || rst_go;
      zq_busy    <= state_reg == MRC_ZQ && cnt_reg != 17'h0
                    || zq_go;
    end
  end

  // ----------------------------------------------------------------------
  // Writable control register; read-only addresses fall through
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst || state_reg == MRC_RESET || rst_go)
      ctrl_reg_q <= CTRL_RESET_VAL;
    else if (idle && is_mrw && cmd_addr == MR_ADDR_CTRL)
      ctrl_reg_q <= cmd_data;
  end

  // Driver impedance defaults after reset, calibration reset or strap
  always_ff @(posedge core_clk) begin
    if (srst)
      drv_default <= 1'b1;
    else if (zq_sync_reg)
      drv_default <= 1'b1;
    else if (state_reg == MRC_ZQ && cnt_reg == 17'h0)
      drv_default <= zq_kind == 2'h3;
  end

  // ----------------------------------------------------------------------
  // Temperature status: sampled at a fixed period equal to the TSI_MS limit,
  // so a value read is no older than that period plus the two synchroniser cycles
  // ----------------------------------------------------------------------
  logic [31:0] tsi_cnt_reg;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tsi_cnt_reg <= 32'h0;
      temp_status <= 3'h0;
    end else if (tsi_cnt_reg >= 32'(TSI_CYCLES - 1)) begin
      tsi_cnt_reg <= 32'h0;
      temp_status <= ts_sync_reg;
    end else begin
      tsi_cnt_reg <= tsi_cnt_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Read burst: four beats, pattern on all DQ for addresses 32 and 40
  // ----------------------------------------------------------------------
  logic [3:0] rd_pat;
  assign rd_pat = cmd_addr == MR_ADDR_PATA ? PAT_A : PAT_B;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dq_oe       <= 1'b0;
      dq_out      <= 16'h0;
      beat_reg    <= 2'h0;
      pat_reg     <= 4'h0;
      pat_sel_reg <= 1'b0;
    end else if (idle && is_mrr) begin
      dq_oe       <= 1'b1;
      beat_reg    <= 2'h1;
      pat_sel_reg <= cmd_addr == MR_ADDR_PATA || cmd_addr == MR_ADDR_PATB;
      pat_reg     <= rd_pat;
      if (cmd_addr == MR_ADDR_PATA || cmd_addr == MR_ADDR_PATB)
        dq_out <= {16{rd_pat[0]}};
      else if (cmd_addr == MR_ADDR_TEMP)
        dq_out <= {13'h0, temp_status};
      else
        dq_out <= {8'h0, ctrl_reg_q};
    end else if (dq_oe) begin
      beat_reg <= beat_reg + 2'h1;
      if (beat_reg == 2'h0)
        dq_oe <= 1'b0;
      if (pat_sel_reg)
        dq_out <= {16{pat_reg[beat_reg]}};
      else if (beat_reg == 2'h0)
        dq_out <= 16'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_burst_len;
    @(posedge core_clk) disable iff (srst)
      $rose(dq_oe) |-> dq_oe [*4] ##1 !dq_oe;
  endproperty
  a_burst_len: assert property (p_burst_len)
    else $error("read burst is not four beats");

  property p_pat_a;
    @(posedge core_clk) disable iff (srst)
      idle && is_mrr && cmd_addr == MR_ADDR_PATA |=>
        dq_out == 16'hffff ##1 dq_out == 16'h0 ##1 dq_out == 16'hffff
        ##1 dq_out == 16'h0;
  endproperty
  a_pat_a: assert property (p_pat_a)
    else $error("pattern A wrong");

  property p_pat_b;
    @(posedge core_clk) disable iff (srst)
      idle && is_mrr && cmd_addr == MR_ADDR_PATB |=>
        dq_out == 16'h0 ##1 dq_out == 16'h0 ##1 dq_out == 16'hffff
        ##1 dq_out == 16'hffff;
  endproperty
  a_pat_b: assert property (p_pat_b)
    else $error("pattern B wrong");

  property p_copy;
    @(posedge core_clk) disable iff (srst)
      dq_oe && pat_sel_reg |-> dq_out == {16{dq_out[0]}};
  endproperty
  a_copy: assert property (p_copy)
    else $error("DQ lines differ in pattern burst");

  property p_ro_write;
    @(posedge core_clk) disable iff (srst)
      idle && is_mrw && cmd_addr == MR_ADDR_TEMP |=> $stable(ctrl_reg_q);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write changed state");

  property p_mrw_take;
    @(posedge core_clk) disable iff (srst)
      idle && is_mrw && cmd_addr == MR_ADDR_CTRL |=>
        ctrl_reg_q == $past(cmd_data);
  endproperty
  a_mrw_take: assert property (p_mrw_take)
    else $error("write data not taken");

  property p_zq_strap;
    @(posedge core_clk) disable iff (srst)
      zq_sync_reg && idle && is_mrw && cmd_addr == MR_ADDR_ZQ |=>
        !zq_busy && state_reg != MRC_ZQ;
  endproperty
  a_zq_strap: assert property (p_zq_strap)
    else $error("calibration ran with strap high");

  property p_mrr_period;
    @(posedge core_clk) disable iff (srst)
      idle && is_mrr |=> !idle ##1 !idle ##1 idle;
  endproperty
  a_mrr_period: assert property (p_mrr_period)
    else $error("read period not two cycles");

  property p_tsi;
    @(posedge core_clk) disable iff (srst)
      tsi_cnt_reg == 32'(TSI_CYCLES - 1) |=>
        temp_status == $past(ts_sync_reg);
  endproperty
  a_tsi: assert property (p_tsi)
    else $error("temperature update interval exceeded");

endmodule : mrc_core

// ---- tb/mrc_ctrl_model.sv ----
// Controller model driving the command/address pins of the block
`timescale 1ns/100ps
module mrc_ctrl_model
  import mrc_pkg::*;
(
  input  wire logic  core_clk,
  output logic       cs_n,
  output logic [9:0] ca_rise,
  output logic [9:0] ca_fall
);
  // ------------------------------------------------------------------
  // Command issue
  // ------------------------------------------------------------------
  // Deselected at time zero
  initial begin
    cs_n    = 1'b1;
    ca_rise = 10'h000;
    ca_fall = 10'h000;
  end

  // One command for one rising edge; op 0 writes, op 8 reads.
  // Only goes out with all banks idle and one device on the resistor.
  task automatic send(input logic [3:0] op, input logic [7:0] addr,
                      input logic [7:0] data);
    @(negedge core_clk);
    cs_n    = 1'b0;
    ca_rise = {addr[5:0], op};
    ca_fall = {data, addr[7:6]};
    @(negedge core_clk);
    // NOP after; CA shows inverted junk so stale values never match
    cs_n    = 1'b1;
    ca_rise = ~ca_rise;
    ca_fall = ~ca_fall;
  endtask : send
endmodule : mrc_ctrl_model

// ---- tb/tb_mode_register_calibration_cmds.sv ----
// Self-checking testbench for the mode register and calibration block
`timescale 1ns/100ps
module tb_mode_register_calibration_cmds;
  import mrc_pkg::*;
  // ------------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------------
  // Short counts keep the run brief; expectations use the same values
  localparam int TSI_T = 50;
  localparam int ZQ_T[4] = '{20, 10, 5, ZQRESET_CYC};
  logic        core_clk = 1'b0;
  logic        srst;
  logic        cs_n;
  logic [9:0]  ca_rise;
  logic [9:0]  ca_fall;
  logic        zq_tied_high;
  logic [2:0]  temp_sense;
  logic [15:0] dq_out;
  logic        dq_oe;
  logic [7:0]  ctrl_reg_q;
  logic [2:0]  temp_status;
  logic        mrw_busy;
  logic        reset_busy;
  logic        zq_busy;
  logic [1:0]  zq_kind;
  logic        drv_default;
  int          miscompares = 0;
  int          checks_done = 0;
  int          n;

  always #5 core_clk = ~core_clk;

  mrc_core #(.TSI_CYCLES(TSI_T), .ZQINIT_CYCLES(20), .ZQCL_CYCLES(10),
    .ZQCS_CYCLES(5)) dut_u (.core_clk(core_clk), .srst(srst),
    .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
    .zq_tied_high(zq_tied_high), .temp_sense(temp_sense),
    .dq_out(dq_out), .dq_oe(dq_oe), .ctrl_reg_q(ctrl_reg_q),
    .temp_status(temp_status), .mrw_busy(mrw_busy),
    .reset_busy(reset_busy), .zq_busy(zq_busy), .zq_kind(zq_kind),
    .drv_default(drv_default));

  mrc_ctrl_model ctrl_u (.core_clk(core_clk), .cs_n(cs_n),
    .ca_rise(ca_rise), .ca_fall(ca_fall));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk_val(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(string what, int exp, int got);
    checks_done++;
    if (got != exp) begin
      miscompares++;
      $display("unexpected %s: expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt

  // Issue a command; returns at the falling edge just past the take edge
  task automatic cmd(logic [3:0] op, logic [7:0] addr, logic [7:0] data);
    ctrl_u.send(op, addr, data);
  endtask : cmd

  // Count cycles a busy flag stays high; bounded so a stuck flag ends
  task automatic busy_len(input int sel, output int cnt);
    logic b;
    cnt = 0;
    b = 1'b1;
    while (b === 1'b1 && cnt < 2000) begin
      b = (sel == 0) ? mrw_busy : (sel == 1) ? zq_busy : reset_busy;
      if (b === 1'b1) begin
        cnt++;
        @(negedge core_clk);
      end
    end
  endtask : busy_len

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_pattern();
    logic [3:0] pat[2];
    logic [7:0] adr[2];
    pat = '{PAT_A, PAT_B};
    adr = '{MR_ADDR_PATA, MR_ADDR_PATB};
    for (int p = 0; p < 2; p++) begin
      cmd(4'h8, adr[p], 8'h00);
      for (int b = 0; b < BURST_BEATS; b++) begin
        chk_val("dq_oe", 16'h1, {15'h0, dq_oe});
        chk_val("dq_out", {16{pat[p][b]}}, dq_out);
        @(negedge core_clk);
      end
      chk_val("dq_oe end", 16'h0, {15'h0, dq_oe});
    end
    $display("test pattern done");
  endtask : t_pattern

  task automatic t_mrw();
    cmd(4'h0, MR_ADDR_CTRL, 8'ha5);
    chk_val("ctrl", 16'h00a5, {8'h0, ctrl_reg_q});
    busy_len(0, n);
    chk_cnt("mrw period", MRW_CYC, n);
    cmd(4'h0, MR_ADDR_CTRL, 8'h3c);
    cmd(4'h0, MR_ADDR_CTRL, 8'hc3);
    busy_len(0, n);
    chk_val("ctrl busy", 16'h003c, {8'h0, ctrl_reg_q});
    cmd(4'h0, 8'h41, 8'hff);
    busy_len(0, n);
    chk_val("ctrl alias", 16'h003c, {8'h0, ctrl_reg_q});
    cmd(4'h0, MR_ADDR_TEMP, 8'h07);
    busy_len(0, n);
    chk_val("temp ro", {13'h0, TEMP_HOT_CODE}, {13'h0, temp_status});
    chk_val("ctrl ro", 16'h003c, {8'h0, ctrl_reg_q});
    $display("test mrw done");
  endtask : t_mrw

  task automatic t_temp();
    // Host polls well inside the update interval
    temp_sense = TEMP_HOT_CODE;
    n = 0;
    while (temp_status !== TEMP_HOT_CODE && n < TSI_T + 8) begin
      n++;
      @(negedge core_clk);
    end
    chk_val("temp", {13'h0, TEMP_HOT_CODE}, {13'h0, temp_status});
    cmd(4'h8, MR_ADDR_TEMP, 8'h00);
    chk_val("mrr temp", {13'h0, TEMP_HOT_CODE}, dq_out);
    repeat (BURST_BEATS + 1) @(negedge core_clk);
    $display("test temp done");
  endtask : t_temp

  task automatic t_zq();
    logic [7:0] code[4];
    code = '{ZQ_CODE_INIT, ZQ_CODE_LONG, ZQ_CODE_SHORT, ZQ_CODE_RESET};
    for (int k = 0; k < 4; k++) begin
      cmd(4'h0, MR_ADDR_ZQ, code[k]);
      chk_val("zq_kind", 16'(k), {14'h0, zq_kind});
      busy_len(1, n);
      chk_cnt("zq period", ZQ_T[k], n);
      chk_val("drv_default", 16'(k == 3), {15'h0, drv_default});
      @(negedge core_clk);
    end
    // Unknown calibration code is a plain write
    cmd(4'h0, MR_ADDR_ZQ, 8'h00);
    chk_val("zq bad code", 16'h0, {15'h0, zq_busy});
    busy_len(0, n);
    chk_cnt("zq bad period", MRW_CYC, n);
    // No resistor fitted: calibration ignored, plain write period
    zq_tied_high = 1'b1;
    repeat (4) @(negedge core_clk);
    cmd(4'h0, MR_ADDR_ZQ, ZQ_CODE_LONG);
    chk_val("zq strap", 16'h0, {15'h0, zq_busy});
    busy_len(0, n);
    chk_val("drv strap", 16'h1, {15'h0, drv_default});
    zq_tied_high = 1'b0;
    $display("test zq done");
  endtask : t_zq

  task automatic t_reset();
    cmd(4'h0, MR_ADDR_RESET, 8'h00);
    chk_val("reset_busy", 16'h1, {15'h0, reset_busy});
    chk_val("ctrl reset", {8'h0, CTRL_RESET_VAL}, {8'h0, ctrl_reg_q});
    busy_len(2, n);
    chk_cnt("reset period", INIT_CYC, n);
    $display("test reset done");
  endtask : t_reset

  // ------------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    zq_tied_high = 1'b0;
    temp_sense = 3'h0;
    repeat (20) @(negedge core_clk);
    chk_val("boot busy", 16'h1, {15'h0, reset_busy});
    chk_val("boot drv", 16'h1, {15'h0, drv_default});
    srst = 1'b0;
    busy_len(2, n);
    t_pattern();
    t_temp();
    t_mrw();
    t_zq();
    t_reset();
    finish_test();
  end

  // Whole run needs about 400 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    finish_test();
  end
endmodule : tb_mode_register_calibration_cmds
